// file: kbwm_top.sv
/*
  Keyboard wake scan code matcher: match registers, make and break
  sequence trackers, power-button status, interrupt and bus slave.
  Assumes scan_valid marks a parity-checked byte from the keyboard
  receiver, synchronous to clk_sys, one cycle per byte.
*/
`timescale 1ns/1ps
`default_nettype none
module kbwm_top
  import kbwm_pkg::*;
#(
  parameter int unsigned PB_RELEASE_CYCLES = kbwm_pkg::KBWM_PB_RELEASE_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [11:0] awaddr,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [11:0] araddr,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  input  wire logic        scan_valid,
  input  wire logic [7:0]  scan_byte,
  output var  logic        wake_event,
  output var  logic        keyboard_power_button_status,
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] make1;
    logic [7:0] make2;
    logic [7:0] break1;
    logic [7:0] break2;
    logic [7:0] break3;
    kbwm_fmt_e  fmt;
    kbwm_rel_e  rel;
    logic [1:0] make_pos;
    logic [1:0] break_pos;
    logic       pb;
    logic [2:0] sts;
    logic [2:0] en;
    logic       irq;
    logic       wake;
  } kbwm_top_s;

  kbwm_top_s q;
  kbwm_top_s next_q;

  kbwm_reg_if regif ();

  logic       timer_expired;
  logic       make_hit;
  logic       make_miss;
  logic       break_hit;
  logic       pb_release;
  logic [2:0] make_step;
  logic [2:0] break_step;
  logic [2:0] clr_bits;

  ////////////////////////////////////////////////////////////////////////
  // Matching helpers

  // Zero stands for any byte
  function automatic logic byte_hit(input logic [7:0] want,
                                    input logic [7:0] got);
    return (want == KBWM_WILDCARD) || (want == got);
  endfunction

  // Format bit 0 set means a two-byte make code
  function automatic logic [1:0] make_len(input kbwm_fmt_e fmt);
    return fmt[0] ? 2'h2 : 2'h1;
  endfunction

  function automatic logic [7:0] make_want(input logic [1:0] pos,
                                           input kbwm_top_s s);
    return (pos == 2'h0) ? s.make1 : s.make2;
  endfunction

  // Set 2 single break is F0 then key, so it uses bytes two and three
  function automatic logic [1:0] break_len(input kbwm_fmt_e fmt);
    logic [1:0] len;
    len = 2'h1;
    unique case (fmt)
      KBWM_FMT_SET1_SINGLE: len = 2'h1;
      KBWM_FMT_SET1_MULTI:  len = 2'h2;
      KBWM_FMT_SET2_SINGLE: len = 2'h2;
      KBWM_FMT_SET2_MULTI:  len = 2'h3;
    endcase
    return len;
  endfunction

  function automatic logic [7:0] break_want(input logic [1:0] pos,
                                            input kbwm_top_s s);
    logic [7:0] want;
    want = s.break1;
    unique case (s.fmt)
      KBWM_FMT_SET1_SINGLE: want = s.break1;
      KBWM_FMT_SET1_MULTI:  want = (pos == 2'h0) ? s.break1 : s.break2;
      KBWM_FMT_SET2_SINGLE: want = (pos == 2'h0) ? s.break2 : s.break3;
      KBWM_FMT_SET2_MULTI: begin
        if (pos == 2'h0) begin
          want = s.break1;
        end else if (pos == 2'h1) begin
          want = s.break2;
        end else begin
          want = s.break3;
        end
      end
    endcase
    return want;
  endfunction

  // Returns {complete, next position}; a mismatch may restart the run
  function automatic logic [2:0] step(input logic [1:0] pos,
                                      input logic [1:0] len,
                                      input logic [7:0] want,
                                      input logic [7:0] first,
                                      input logic [7:0] got);
    logic [2:0] r;
    r = 3'h0;
    if (byte_hit(want, got)) begin
      if (pos + 2'h1 == len) begin
        r = 3'h4;
      end else begin
        r = {1'b0, pos + 2'h1};
      end
    end else if (pos != 2'h0 && byte_hit(first, got)) begin
      // The failing byte may itself open a new run
      r = (len == 2'h1) ? 3'h4 : 3'h1;
    end
    return r;
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] idx,
                                          input kbwm_top_s s);
    logic [7:0] d;
    d = 8'h00;
    unique case (idx)
      KBWM_IDX_MAKE1:  d = s.make1;
      KBWM_IDX_MAKE2:  d = s.make2;
      KBWM_IDX_BREAK1: d = s.break1;
      KBWM_IDX_BREAK2: d = s.break2;
      KBWM_IDX_BREAK3: d = s.break3;
      KBWM_IDX_CONFIG: begin
        d[KBWM_FIXED_ONE_BIT] = 1'b1;
        d[KBWM_REL_LSB +: 2] = s.rel;
        d[KBWM_FMT_LSB +: 2] = s.fmt;
      end
      KBWM_IDX_STATUS: d = {5'h00, s.sts};
      KBWM_IDX_ENABLE: d = {5'h00, s.en};
      default:         d = 8'h00;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and release timer

  kbwm_axil_slave u_slave (
    .clk_sys (clk_sys),
    .reset   (reset),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .regif   (regif.slave)
  );

  assign regif.rd_data = read_reg(regif.rd_idx, q);

  // Restarted by every make match; stopped when status drops another way
  kbwm_release_timer #(
    .CYCLES (PB_RELEASE_CYCLES)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .start   (make_hit),
    .stop    (pb_release && !timer_expired),
    .expired (timer_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequence trackers and events

  assign make_step  = step(q.make_pos, make_len(q.fmt),
                           make_want(q.make_pos, q), q.make1, scan_byte);
  assign break_step = step(q.break_pos, break_len(q.fmt),
                           break_want(q.break_pos, q),
                           break_want(2'h0, q), scan_byte);

  assign make_hit  = scan_valid && make_step[2];
  assign break_hit = scan_valid && break_step[2];
  // Any byte that does not advance the make sequence
  assign make_miss = scan_valid && !make_step[2] &&
                     !byte_hit(make_want(q.make_pos, q), scan_byte);

  // Delay mode leaves the end of the pulse to the timer
  always_comb begin
    pb_release = 1'b0;
    unique case (q.rel)
      KBWM_REL_DELAY:     pb_release = timer_expired;
      KBWM_REL_OTHER_KEY: pb_release = make_miss;
      KBWM_REL_BREAK:     pb_release = break_hit;
      // Reserved code falls back to the fixed delay
      KBWM_REL_RESERVED:  pb_release = timer_expired;
    endcase
  end

  // Clear acts only where the written data holds ones
  assign clr_bits = (regif.wr_pulse && regif.wr_idx == KBWM_IDX_CLEAR)
                    ? regif.wr_data[2:0] : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_q = q;
    next_q.wake = make_hit;
    if (scan_valid) begin
      next_q.make_pos  = make_step[1:0];
      next_q.break_pos = break_step[1:0];
    end
    if (regif.wr_pulse) begin
      unique case (regif.wr_idx)
        KBWM_IDX_MAKE1:  next_q.make1 = regif.wr_data;
        KBWM_IDX_MAKE2:  next_q.make2 = regif.wr_data;
        KBWM_IDX_BREAK1: next_q.break1 = regif.wr_data;
        KBWM_IDX_BREAK2: next_q.break2 = regif.wr_data;
        KBWM_IDX_BREAK3: next_q.break3 = regif.wr_data;
        KBWM_IDX_CONFIG: begin
          next_q.fmt = kbwm_fmt_e'(regif.wr_data[KBWM_FMT_LSB +: 2]);
          next_q.rel = kbwm_rel_e'(regif.wr_data[KBWM_REL_LSB +: 2]);
          // New format invalidates partial progress
          next_q.make_pos = 2'h0;
          next_q.break_pos = 2'h0;
        end
        KBWM_IDX_ENABLE: next_q.en = regif.wr_data[2:0];
        default: begin
        end
      endcase
    end
    // A new make match outranks any release in the same cycle
    if (make_hit) begin
      next_q.pb = 1'b1;
    end else if (pb_release) begin
      next_q.pb = 1'b0;
    end
    // Status takes no direct writes; only the clear register lowers it
    // Hardware set wins over software clear
    next_q.sts = (q.sts & ~clr_bits) |
                 {q.pb && pb_release && !make_hit, break_hit, make_hit};
    next_q.irq = |(next_q.sts & next_q.en);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q        <= '0;
      // Match registers wake up holding the power key codes
      q.make1  <= KBWM_RST_MAKE1;
      q.make2  <= KBWM_RST_MAKE2;
      q.break1 <= KBWM_RST_BREAK1;
      q.break2 <= KBWM_RST_BREAK2;
      q.break3 <= KBWM_RST_BREAK3;
      q.fmt    <= kbwm_fmt_e'(KBWM_RST_CONFIG[KBWM_FMT_LSB +: 2]);
      q.rel    <= kbwm_rel_e'(KBWM_RST_CONFIG[KBWM_REL_LSB +: 2]);
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign wake_event                   = q.wake;
  assign keyboard_power_button_status = q.pb;
  assign irq                          = q.irq;

endmodule // kbwm_top
`default_nettype wire

// file: kbwm_pkg.sv
/*
  Constants, register map and helpers of the keyboard wake scan code
  matcher. Assumes a 50 MHz system clock and word-aligned AXI4-Lite.
*/
// Summary of operation
// - Second make byte checked for multi-byte codes only
// - Break byte one checked first in break sequences, except set 2 single
// - Break byte two checked second in multi-byte breaks, except set 2 single where it is first
// - Break byte three checked third in set 2 multi-byte, second in set 2 single
// - Zero in a match register matches anything
// - Reset loads set 2 power key codes
// - Each match register is eight bit read/write
// - First make byte checked; resets to E0
// - Two-bit selector picks set and byte count
// - Release field decides when power-button status drops
`default_nettype none
package kbwm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] KBWM_IDX_MAKE1   = 8'h5F;
  localparam logic [7:0] KBWM_IDX_MAKE2   = 8'h60;
  localparam logic [7:0] KBWM_IDX_BREAK1  = 8'h61;
  localparam logic [7:0] KBWM_IDX_BREAK2  = 8'h62;
  localparam logic [7:0] KBWM_IDX_BREAK3  = 8'h63;
  localparam logic [7:0] KBWM_IDX_CONFIG  = 8'h64;
  localparam logic [7:0] KBWM_IDX_STATUS  = 8'h70;
  localparam logic [7:0] KBWM_IDX_CLEAR   = 8'h71;
  localparam logic [7:0] KBWM_IDX_ENABLE  = 8'h72;

  // Values after reset
  localparam logic [7:0] KBWM_RST_MAKE1   = 8'hE0;
  localparam logic [7:0] KBWM_RST_MAKE2   = 8'h37;
  localparam logic [7:0] KBWM_RST_BREAK1  = 8'hE0;
  localparam logic [7:0] KBWM_RST_BREAK2  = 8'hF0;
  localparam logic [7:0] KBWM_RST_BREAK3  = 8'h37;
  localparam logic [7:0] KBWM_RST_CONFIG  = 8'h6C;
  localparam logic [7:0] KBWM_WILDCARD    = 8'h00;

  // Config field positions
  localparam int KBWM_FMT_LSB = 2;
  localparam int KBWM_REL_LSB = 4;
  localparam int KBWM_FIXED_ONE_BIT = 6;

  // Status bit positions
  localparam int KBWM_STS_MAKE    = 0;
  localparam int KBWM_STS_BREAK   = 1;
  localparam int KBWM_STS_RELEASE = 2;

  localparam logic [1:0] KBWM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] KBWM_RESP_SLVERR = 2'h2;

  // Fixed-delay release time
  localparam longint KBWM_CLK_HZ         = 50000000;
  localparam longint KBWM_PB_RELEASE_MS  = 1000;
  localparam int unsigned KBWM_PB_RELEASE_CYCLES =
    int'((KBWM_PB_RELEASE_MS * KBWM_CLK_HZ + 999) / 1000);

  typedef enum logic [1:0] {
    KBWM_FMT_SET1_SINGLE,
    KBWM_FMT_SET1_MULTI,
    KBWM_FMT_SET2_SINGLE,
    KBWM_FMT_SET2_MULTI
  } kbwm_fmt_e;

  typedef enum logic [1:0] {
    KBWM_REL_DELAY,
    KBWM_REL_OTHER_KEY,
    KBWM_REL_BREAK,
    KBWM_REL_RESERVED
  } kbwm_rel_e;

  function automatic logic kbwm_idx_mapped(input logic [7:0] idx);
    return (idx >= KBWM_IDX_MAKE1 && idx <= KBWM_IDX_CONFIG) ||
           (idx >= KBWM_IDX_STATUS && idx <= KBWM_IDX_ENABLE);
  endfunction

endpackage
`default_nettype wire

// file: kbwm_reg_if.sv
/*
  Register access carrier between the bus slave and the register file.
  Assumes one clock domain; all signals are sampled on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface kbwm_reg_if;
  logic       wr_pulse;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;

  modport slave (output wr_pulse, output wr_idx, output wr_data,
                 output rd_idx, input rd_data);
  modport regs  (input wr_pulse, input wr_idx, input wr_data,
                 input rd_idx, output rd_data);
endinterface
`default_nettype wire

// file: kbwm_axil_slave.sv
/*
  AXI4-Lite slave: one write and one read at a time, lane 0 only.
  Assumes the register side answers reads combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module kbwm_axil_slave
  import kbwm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [11:0] awaddr,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [11:0] araddr,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  kbwm_reg_if.slave        regif
);
  typedef struct packed {
    logic        awready;
    logic        aw_got;
    logic [7:0]  aw_idx;
    logic        wready;
    logic        w_got;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        wr_pulse;
  } kbwm_axil_s;

  kbwm_axil_s q;
  kbwm_axil_s next_q;

  assign awready        = q.awready;
  assign wready         = q.wready;
  assign bvalid         = q.bvalid;
  assign bresp          = q.bresp;
  assign arready        = q.arready;
  assign rvalid         = q.rvalid;
  assign rdata          = q.rdata;
  assign rresp          = q.rresp;
  assign regif.wr_pulse = q.wr_pulse;
  assign regif.wr_idx   = q.aw_idx;
  assign regif.wr_data  = q.w_data;
  assign regif.rd_idx   = araddr[9:2];

  always_comb begin
    next_q = q;
    next_q.wr_pulse = 1'b0;
    if (awvalid && q.awready) begin
      next_q.aw_got = 1'b1;
      next_q.aw_idx = awaddr[9:2];
      next_q.awready = 1'b0;
    end
    if (wvalid && q.wready) begin
      next_q.w_got = 1'b1;
      next_q.w_data = wdata[7:0];
      next_q.w_lane0 = wstrb[0];
      next_q.wready = 1'b0;
    end
    // Write commits once both halves are in and no response is pending
    if (q.aw_got && q.w_got && !q.bvalid) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.wr_pulse = q.w_lane0 && kbwm_idx_mapped(q.aw_idx);
      next_q.bresp = kbwm_idx_mapped(q.aw_idx) ? KBWM_RESP_OKAY
                                               : KBWM_RESP_SLVERR;
    end
    if (q.bvalid && bready) begin
      next_q.bvalid = 1'b0;
    end
    if (!q.aw_got && !q.bvalid && !(awvalid && q.awready)) begin
      next_q.awready = 1'b1;
    end
    if (!q.w_got && !q.bvalid && !(wvalid && q.wready)) begin
      next_q.wready = 1'b1;
    end
    if (arvalid && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rdata = {24'h000000, regif.rd_data};
      next_q.rresp = kbwm_idx_mapped(araddr[9:2]) ? KBWM_RESP_OKAY
                                                  : KBWM_RESP_SLVERR;
    end else if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
    end else if (!q.rvalid) begin
      next_q.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule // kbwm_axil_slave
`default_nettype wire

// file: kbwm_release_timer.sv
/*
  One-shot timer for the fixed-delay power-button release.
  Assumes start and stop are single-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module kbwm_release_timer #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic stop,
  output var  logic expired
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        expired;
  } kbwm_tmr_s;

  kbwm_tmr_s q;
  kbwm_tmr_s next_q;

  assign expired = q.expired;

  always_comb begin
    next_q = q;
    next_q.expired = 1'b0;
    if (start) begin
      next_q.run = 1'b1;
      next_q.cnt = 32'(CYCLES - 1);
    end else if (stop) begin
      next_q.run = 1'b0;
    end else if (q.run) begin
      if (q.cnt == 32'h0) begin
        next_q.run = 1'b0;
        next_q.expired = 1'b1;
      end else begin
        next_q.cnt = q.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule // kbwm_release_timer
`default_nettype wire

// file: kbwm_top_asserts.sv
/*
  Port checker of the scan code matcher: bus timing and wake outputs.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module kbwm_top_asserts #(
  parameter int unsigned PB_RELEASE_CYCLES = 20
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        scan_valid,
  input wire logic        wake_event,
  input wire logic        keyboard_power_button_status,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  chk_wake_one_cycle: assert property (wake_event |=> !wake_event)
    else $error("wake pulse lasted more than one cycle");
  chk_wake_from_byte: assert property (wake_event |-> $past(scan_valid))
    else $error("wake without a received byte");
  chk_wake_sets_pb: assert property (
    wake_event |-> keyboard_power_button_status)
    else $error("power button status low on wake");
  chk_pb_rise_cause: assert property (
    $rose(keyboard_power_button_status) |-> wake_event)
    else $error("power button status rose without wake");
  chk_wr_resp_time: assert property (s_wr_both |-> ##2 bvalid)
    else $error("write response late");
  chk_rd_resp_time: assert property (
    s_rd_take |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read response late or upper bits set");
  chk_b_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  chk_r_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  chk_quiet_after_reset: assert property (
    $fell(reset) |-> !wake_event && !irq && !keyboard_power_button_status
    && !bvalid && !rvalid)
    else $error("outputs active after reset");
endmodule // kbwm_top_asserts

bind kbwm_top kbwm_top_asserts #(.PB_RELEASE_CYCLES(PB_RELEASE_CYCLES)) chk_u (
  .clk_sys, .reset, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .scan_valid,
  .wake_event, .keyboard_power_button_status, .irq);
`default_nettype wire

// file: kbwm_kbd_model.sv
/*
  Keyboard side model: one checked scan byte per call, as a pulse.
  Assumes the caller runs off the clock edge in one process.
*/
`timescale 1ns/1ps
`default_nettype none
module kbwm_kbd_model (
  input  wire logic       clk_sys,
  output var  logic       scan_valid,
  output var  logic [7:0] scan_byte
);
  initial begin
    scan_valid = 1'b0;
    scan_byte  = 8'h00;
  end

  // Idle byte is the inverse of the last, so a stale byte never matches
  task automatic send(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    scan_valid <= 1'b1;
    scan_byte  <= b;
    @(posedge clk_sys);
    scan_valid <= 1'b0;
    scan_byte  <= ~b;
  endtask
endmodule // kbwm_kbd_model
`default_nettype wire

// file: kbwm_top_test.sv
/*
  Self-checking bench of the scan code matcher over AXI4-Lite.
  Assumes the keyboard model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_kbwm_top;
  import kbwm_pkg::*;
  localparam int unsigned PB_CYC = 20;
  logic        clk_sys, reset, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, wake_event;
  logic        keyboard_power_button_status, irq, scan_valid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  scan_byte;
  int          error_cnt, samples_checked, cyc, bus_slow;
  logic [7:0]  idx_tab [5] = '{KBWM_IDX_MAKE1, KBWM_IDX_MAKE2,
    KBWM_IDX_BREAK1, KBWM_IDX_BREAK2, KBWM_IDX_BREAK3};
  logic [7:0]  rst_tab [5] = '{8'hE0, 8'h37, 8'hE0, 8'hF0, 8'h37};
  logic [23:0] brk_b [4] = '{24'hA10000, 24'hA1A200, 24'hA2A300, 24'hA1A2A3};
  int          brk_n [4] = '{1, 2, 2, 3};

  kbwm_top #(.PB_RELEASE_CYCLES(PB_CYC)) dut_u (.clk_sys, .reset,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .scan_valid, .scan_byte, .wake_event,
    .keyboard_power_button_status, .irq);
  kbwm_kbd_model kbd_u (.clk_sys, .scan_valid, .scan_byte);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hung handshake ends here instead of running forever
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic flag(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] d,
                           output logic [1:0] resp);
    logic done;
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk_sys);
      done = (!awvalid || awready) && (!wvalid || wready);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    repeat (bus_slow) @(posedge clk_sys);
    bready <= 1'b1;
    do @(posedge clk_sys); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] d,
                          output logic [1:0] resp);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    repeat (bus_slow) @(posedge clk_sys);
    rready <= 1'b1;
    do @(posedge clk_sys); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    axi_write(idx, d, r);
    check("bresp", {30'h0, r}, {30'h0, KBWM_RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(idx, d, r);
    check($sformatf("reg %h", idx), d, {24'h0, exp});
  endtask

  // Sends n bytes, highest first, then looks at the wake pulse
  task automatic keys(input int n, input logic [23:0] b, input int gap,
                      input logic w);
    for (int i = 0; i < n; i++) kbd_u.send(b[23-8*i -: 8], gap);
    @(posedge clk_sys);
    flag("wake_event", wake_event, w);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {reset, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
    bus_slow = 3;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (idx_tab[i]) rd(idx_tab[i], rst_tab[i]);
    axi_read(KBWM_IDX_CONFIG, d, r);
    check("format", {30'h0, d[3:2]}, 32'h3);
    for (int p = 0; p < 2; p++) begin
      foreach (idx_tab[i]) wr(idx_tab[i], (p ? 8'h5A : 8'hA5) + i[7:0]);
      foreach (idx_tab[i]) rd(idx_tab[i], (p ? 8'h5A : 8'hA5) + i[7:0]);
      bus_slow = 0;
    end
    axi_read(8'h50, d, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, KBWM_RESP_SLVERR});
    check("unmapped rdata", d, 32'h0);
    axi_write(8'h50, 8'h00, r);
    check("unmapped bresp", {30'h0, r}, {30'h0, KBWM_RESP_SLVERR});
    foreach (idx_tab[i]) wr(idx_tab[i], rst_tab[i]);
    wr(KBWM_IDX_ENABLE, 8'h07);
    keys(2, 24'hE01200, 0, 1'b0);
    keys(3, 24'hE0E037, 2, 1'b1);
    @(posedge clk_sys);
    flag("irq", irq, 1'b1);
    rd(KBWM_IDX_STATUS, 8'h01);
    wr(KBWM_IDX_CLEAR, 8'h07);
    wr(KBWM_IDX_STATUS, 8'hFF);
    rd(KBWM_IDX_STATUS, 8'h00);
    flag("irq", irq, 1'b0);
    wr(KBWM_IDX_ENABLE, 8'h00);
    keys(2, 24'hE03700, 0, 1'b1);
    keys(3, 24'hE0F037, 1, 1'b0);
    flag("pb", keyboard_power_button_status, 1'b0);
    rd(KBWM_IDX_STATUS, 8'h07);
    flag("irq", irq, 1'b0);
    wr(KBWM_IDX_ENABLE, 8'h07);
    repeat (2) @(posedge clk_sys);
    flag("irq", irq, 1'b1);
    wr(KBWM_IDX_CLEAR, 8'h07);
    wr(KBWM_IDX_BREAK1, 8'hA1);
    wr(KBWM_IDX_BREAK2, 8'hA2);
    wr(KBWM_IDX_BREAK3, 8'hA3);
    for (int f = 0; f < 4; f++) begin
      wr(KBWM_IDX_CONFIG, {4'h6, f[1:0], 2'b00});
      keys(f[0] ? 2 : 1, 24'hE03700, 0, 1'b1);
      keys(brk_n[f], brk_b[f], 0, 1'b0);
      flag("pb", keyboard_power_button_status, 1'b0);
    end
    foreach (idx_tab[i]) wr(idx_tab[i], rst_tab[i]);
    wr(KBWM_IDX_MAKE2, 8'h00);
    keys(2, 24'hE05A00, 0, 1'b1);
    wr(KBWM_IDX_MAKE2, 8'h37);
    wstrb <= 4'hE;
    wr(KBWM_IDX_MAKE2, 8'h11);
    wstrb <= 4'hF;
    rd(KBWM_IDX_MAKE2, 8'h37);
    wr(KBWM_IDX_CONFIG, 8'h5C);
    keys(2, 24'hE03700, 0, 1'b1);
    keys(1, 24'h120000, 0, 1'b0);
    flag("pb", keyboard_power_button_status, 1'b0);
    wr(KBWM_IDX_CONFIG, 8'h4C);
    keys(2, 24'hE03700, 0, 1'b1);
    repeat (PB_CYC - 5) @(posedge clk_sys);
    flag("pb", keyboard_power_button_status, 1'b1);
    repeat (10) @(posedge clk_sys);
    flag("pb", keyboard_power_button_status, 1'b0);
    wr(KBWM_IDX_CONFIG, 8'h7C);
    keys(2, 24'hE03700, 0, 1'b1);
    flag("pb", keyboard_power_button_status, 1'b1);
    repeat (PB_CYC + 5) @(posedge clk_sys);
    flag("pb", keyboard_power_button_status, 1'b0);
    end_of_test();
  end
endmodule // test_kbwm_top
`default_nettype wire
